// *** verilog/interrupt_response_and_enable.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "irq_resp_params.svh"

// Notes on behaviour
// - Flags may change in any clock cycle
// - Poll at instruction end, previous-cycle values
// - Unblocked enabled request injects call next
// - Equal or higher level running blocks vectoring
// - Return or enable/priority write blocks one instruction
// - Denied requests are not remembered
// - Injected call lasts four cycles
// - Extra latency bounded by instruction length
// - Single-interrupt latency between 5 and 14 cycles
// - Shared vector requests while any source set
// - External inputs level or edge, latched flag
// - Acknowledge clears external flag only in edge mode
// - Timer overflow flags set on rollover, cleared on vectoring
// - Global gate masks all, else per-source enable
// - Enable register zero resets zero, seven sources
// - Enable register one resets zero, five sources
// - Two-bit levels, only strictly higher preempts
// - Equal level resolved by fixed polling order
// - Software flag writes act like hardware, except level-mode external flags follow the pin
module interrupt_response_and_enable (
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst,
  input  wire logic                         i_ce,
  input  wire irq_resp_pkg::reg_req_s       i_reg,
  output logic [7:0]                        o_reg_rdata,
  input  wire logic                         i_ext_req_zero,
  input  wire logic                         i_ext_req_one,
  input  wire logic                         i_timer_zero_rollover,
  input  wire logic                         i_timer_one_rollover,
  input  wire irq_resp_pkg::periph_flags_s  i_periph_flags,
  input  wire logic                         i_instr_last,
  input  wire logic                         i_instr_return_from_interrupt,
  output logic                              o_call_req,
  output logic [15:0]                       o_call_vector,
  output logic [3:0]                        o_active_levels
);
  import irq_resp_pkg::*;
  localparam int NSRC = 12;
  localparam logic [2:0] CALL_LAST = 3'(`IRQ_CALL_CYCLES - 1);
  // Polling-order index of each source
  localparam int S_EXT0 = 0;
  localparam int S_TMR0 = 1;
  localparam int S_EXT1 = 2;
  localparam int S_TMR1 = 3;
  // Pin synchroniser state
  logic [1:0] ext_meta_q, ext_meta_d;
  logic [1:0] ext_sync_q, ext_sync_d;
  logic [1:0] ext_prev_q, ext_prev_d;
  // Register file state
  logic [7:0] en0_q, en0_d;
  logic [7:0] en1_q, en1_d;
  logic [7:0] pl0_q, pl0_d;
  logic [7:0] pl1_q, pl1_d;
  logic [7:0] ph0_q, ph0_d;
  logic [7:0] ph1_q, ph1_d;
  logic [7:0] flags_q, flags_d;
  logic [7:0] rdata_q, rdata_d;
  // Controller state
  call_state_e state_q, state_d;
  logic [2:0]  cnt_q, cnt_d;
  src_vec_t    req_q, req_d;
  logic        blk_q, blk_d;
  logic [3:0]  active_q, active_d;
  logic        call_q, call_d;
  logic [15:0] vec_q, vec_d;
  // Combinational helpers
  src_vec_t   en_vec, lo_vec, hi_vec, elig;
  logic [1:0] lvl [NSRC];
  logic [3:0] lvl_dis;
  logic       wr_irq_reg, blocked, found, accept;
  logic [3:0] sel_idx;
  logic [1:0] sel_lvl;
  logic [1:0] top_lvl;
  logic       any_active;
  logic [1:0] ext_rise;
  // Map zero/one register bits into polling order
  function automatic src_vec_t map_bits(input logic [7:0] r0, input logic [7:0] r1);
    map_bits = {r1[5], r1[4], r1[2], r1[1], r1[0], r0[5], r0[4], r0[6],
                r0[3], r0[2], r0[1], r0[0]};
  endfunction
  // Vector address of each polling-order index
  localparam logic [15:0] VEC_TAB [NSRC] = '{`IRQ_VEC_EXT0, `IRQ_VEC_TMR0, `IRQ_VEC_EXT1,
    `IRQ_VEC_TMR1, `IRQ_VEC_CARRAY, `IRQ_VEC_SERIAL, `IRQ_VEC_TMR2, `IRQ_VEC_KEYBD,
    `IRQ_VEC_TWOWIRE, `IRQ_VEC_SPI, `IRQ_VEC_COMPAR, `IRQ_VEC_CONVERT};

  // Two-flop synchroniser plus edge history on external pins
  always_comb begin
    ext_meta_d = {i_ext_req_one, i_ext_req_zero};
    ext_sync_d = ext_meta_q;
    ext_prev_d = ext_sync_q;
    ext_rise   = ext_sync_q & ~ext_prev_q;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ext_meta_q <= 2'h0;
      ext_sync_q <= 2'h0;
      ext_prev_q <= 2'h0;
    end else if (i_ce) begin
      ext_meta_q <= ext_meta_d;
      ext_sync_q <= ext_sync_d;
      ext_prev_q <= ext_prev_d;
    end
  end

  // Per-source enable and level views
  always_comb begin
    en_vec  = map_bits(en0_q, en1_q);
    lo_vec  = map_bits(pl0_q, pl1_q);
    hi_vec  = map_bits(ph0_q, ph1_q);
    lvl_dis = {ph1_q[`IRQ_BIT_LVL_DIS], pl1_q[`IRQ_BIT_LVL_DIS],
               ph0_q[`IRQ_BIT_LVL_DIS], pl0_q[`IRQ_BIT_LVL_DIS]};
    for (int i = 0; i < NSRC; i++) begin
      lvl[i] = {hi_vec[i], lo_vec[i]};
    end
  end

  // Highest level whose routine is still running
  always_comb begin
    any_active = |active_q;
    top_lvl    = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (active_q[l]) begin
        top_lvl = 2'(l);
      end
    end
  end

  // Eligibility and winner selection
  always_comb begin
    found   = 1'b0;
    sel_idx = 4'h0;
    sel_lvl = 2'h0;
    for (int i = 0; i < NSRC; i++) begin
      elig[i] = req_q[i] & en_vec[i] & en0_q[`IRQ_BIT_GATE]
                & ~lvl_dis[lvl[i]]
                & (~any_active | (lvl[i] > top_lvl));
      if (elig[i] && (!found || lvl[i] > sel_lvl)) begin
        found   = 1'b1;
        sel_idx = 4'(i);
        sel_lvl = lvl[i];
      end
    end
  end

  // Blocking conditions for the current instruction
  always_comb begin
    wr_irq_reg = i_reg.wr && (i_reg.addr == `IRQ_ADDR_EN0 || i_reg.addr == `IRQ_ADDR_EN1
                 || i_reg.addr == `IRQ_ADDR_PL0 || i_reg.addr == `IRQ_ADDR_PL1
                 || i_reg.addr == `IRQ_ADDR_PH0 || i_reg.addr == `IRQ_ADDR_PH1);
    blocked    = i_instr_return_from_interrupt | blk_q | wr_irq_reg;
    accept     = i_instr_last & (state_q == CALL_IDLE) & ~blocked & found;
  end

  // Register file and source flags
  always_comb begin
    en0_d   = en0_q;
    en1_d   = en1_q;
    pl0_d   = pl0_q;
    pl1_d   = pl1_q;
    ph0_d   = ph0_q;
    ph1_d   = ph1_q;
    flags_d = flags_q;
    rdata_d = 8'h00;
    // Software writes
    if (i_reg.wr) begin
      if (i_reg.addr == `IRQ_ADDR_EN0) begin
        en0_d = i_reg.wdata;
      end else if (i_reg.addr == `IRQ_ADDR_EN1) begin
        en1_d = i_reg.wdata & `IRQ_MASK_EN1;
      end else if (i_reg.addr == `IRQ_ADDR_PL0) begin
        pl0_d = i_reg.wdata;
      end else if (i_reg.addr == `IRQ_ADDR_PL1) begin
        pl1_d = i_reg.wdata & `IRQ_MASK_PRIO1;
      end else if (i_reg.addr == `IRQ_ADDR_PH0) begin
        ph0_d = i_reg.wdata;
      end else if (i_reg.addr == `IRQ_ADDR_PH1) begin
        ph1_d = i_reg.wdata & `IRQ_MASK_PRIO1;
      end else if (i_reg.addr == `IRQ_ADDR_FLAGS) begin
        flags_d = i_reg.wdata & `IRQ_MASK_FLAGS;
      end
    end
    // Hardware clears on acknowledge
    if (accept) begin
      if (sel_idx == 4'(S_EXT0) && flags_q[`IRQ_BIT_EXT0_TYP]) begin
        flags_d[`IRQ_BIT_EXT0_FLG] = 1'b0;
      end
      if (sel_idx == 4'(S_EXT1) && flags_q[`IRQ_BIT_EXT1_TYP]) begin
        flags_d[`IRQ_BIT_EXT1_FLG] = 1'b0;
      end
      if (sel_idx == 4'(S_TMR0)) begin
        flags_d[`IRQ_BIT_TMR0_OVF] = 1'b0;
      end
      if (sel_idx == 4'(S_TMR1)) begin
        flags_d[`IRQ_BIT_TMR1_OVF] = 1'b0;
      end
    end
    // Hardware sets win over any clear
    if (i_timer_zero_rollover) begin
      flags_d[`IRQ_BIT_TMR0_OVF] = 1'b1;
    end
    if (i_timer_one_rollover) begin
      flags_d[`IRQ_BIT_TMR1_OVF] = 1'b1;
    end
    if (flags_q[`IRQ_BIT_EXT0_TYP]) begin
      flags_d[`IRQ_BIT_EXT0_FLG] = flags_d[`IRQ_BIT_EXT0_FLG] | ext_rise[0];
    end else begin
      flags_d[`IRQ_BIT_EXT0_FLG] = ext_sync_q[0];
    end
    if (flags_q[`IRQ_BIT_EXT1_TYP]) begin
      flags_d[`IRQ_BIT_EXT1_FLG] = flags_d[`IRQ_BIT_EXT1_FLG] | ext_rise[1];
    end else begin
      flags_d[`IRQ_BIT_EXT1_FLG] = ext_sync_q[1];
    end
    // Read data, one cycle later
    if (i_reg.rd) begin
      if (i_reg.addr == `IRQ_ADDR_EN0) begin
        rdata_d = en0_q;
      end else if (i_reg.addr == `IRQ_ADDR_EN1) begin
        rdata_d = en1_q;
      end else if (i_reg.addr == `IRQ_ADDR_PL0) begin
        rdata_d = pl0_q;
      end else if (i_reg.addr == `IRQ_ADDR_PL1) begin
        rdata_d = pl1_q;
      end else if (i_reg.addr == `IRQ_ADDR_PH0) begin
        rdata_d = ph0_q;
      end else if (i_reg.addr == `IRQ_ADDR_PH1) begin
        rdata_d = ph1_q;
      end else if (i_reg.addr == `IRQ_ADDR_FLAGS) begin
        rdata_d = flags_q;
      end else if (i_reg.addr == `IRQ_ADDR_ACTIVE) begin
        rdata_d = {4'h0, active_q};
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      en0_q   <= `IRQ_RST_EN0;
      en1_q   <= `IRQ_RST_EN1;
      pl0_q   <= `IRQ_RST_PRIO;
      pl1_q   <= `IRQ_RST_PRIO;
      ph0_q   <= `IRQ_RST_PRIO;
      ph1_q   <= `IRQ_RST_PRIO;
      flags_q <= `IRQ_RST_FLAGS;
      rdata_q <= 8'h00;
    end else if (i_ce) begin
      en0_q   <= en0_d;
      en1_q   <= en1_d;
      pl0_q   <= pl0_d;
      pl1_q   <= pl1_d;
      ph0_q   <= ph0_d;
      ph1_q   <= ph1_d;
      flags_q <= flags_d;
      rdata_q <= rdata_d;
    end
  end

  // Request sampling, blocking, level tracking and call injection
  always_comb begin
    // Shared vectors request while any source bit is set
    req_d = {i_periph_flags.converter, |i_periph_flags.comparator,
             |i_periph_flags.serial_periph, i_periph_flags.two_wire_port,
             |i_periph_flags.keyboard, |i_periph_flags.timer_two,
             |i_periph_flags.serial_port, |i_periph_flags.counter_array,
             flags_q[`IRQ_BIT_TMR1_OVF], flags_q[`IRQ_BIT_EXT1_FLG],
             flags_q[`IRQ_BIT_TMR0_OVF], flags_q[`IRQ_BIT_EXT0_FLG]};
    blk_d    = i_instr_last ? 1'b0 : (blk_q | wr_irq_reg);
    active_d = active_q;
    state_d  = state_q;
    cnt_d    = cnt_q;
    call_d   = 1'b0;
    vec_d    = vec_q;
    // Return pops the highest running level
    if (i_instr_last && i_instr_return_from_interrupt) begin
      active_d[top_lvl] = 1'b0;
    end
    case (state_q)
      CALL_IDLE: begin
        if (accept) begin
          call_d            = 1'b1;
          vec_d             = VEC_TAB[sel_idx];
          active_d[sel_lvl] = 1'b1;
          cnt_d             = 3'h0;
          state_d           = CALL_BUSY;
        end
      end
      CALL_BUSY: begin
        if (cnt_q == CALL_LAST) begin
          state_d = CALL_IDLE;
        end else begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      default: begin
        state_d = CALL_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_q  <= CALL_IDLE;
      cnt_q    <= 3'h0;
      req_q    <= '0;
      blk_q    <= 1'b0;
      active_q <= 4'h0;
      call_q   <= 1'b0;
      vec_q    <= 16'h0000;
    end else if (i_ce) begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      req_q    <= req_d;
      blk_q    <= blk_d;
      active_q <= active_d;
      call_q   <= call_d;
      vec_q    <= vec_d;
    end
  end

  // Registered outputs
  assign o_reg_rdata     = rdata_q;
  assign o_call_req      = call_q;
  assign o_call_vector   = vec_q;
  assign o_active_levels = active_q;
endmodule // interrupt_response_and_enable

`default_nettype wire

// *** verilog/irq_resp_params.svh ***
`ifndef IRQ_RESP_PARAMS_SVH
`define IRQ_RESP_PARAMS_SVH

// Register offsets on the plain register port
`define IRQ_ADDR_EN0     8'ha8
`define IRQ_ADDR_EN1     8'hb1
`define IRQ_ADDR_PL0     8'hb8
`define IRQ_ADDR_PL1     8'hb2
`define IRQ_ADDR_PH0     8'hb7
`define IRQ_ADDR_PH1     8'hb3
`define IRQ_ADDR_FLAGS   8'hc8
`define IRQ_ADDR_ACTIVE  8'hc9

// Reset values
`define IRQ_RST_EN0      8'h00
`define IRQ_RST_EN1      8'h00
`define IRQ_RST_PRIO     8'h00
`define IRQ_RST_FLAGS    8'h00

// Writable masks, unused bits read as zero
`define IRQ_MASK_EN1     8'h37
`define IRQ_MASK_PRIO1   8'hb7

// Field positions
`define IRQ_BIT_GATE     7
`define IRQ_BIT_LVL_DIS  7
`define IRQ_BIT_EXT0_TYP 0
`define IRQ_BIT_EXT0_FLG 1
`define IRQ_BIT_EXT1_TYP 2
`define IRQ_BIT_EXT1_FLG 3
`define IRQ_BIT_TMR0_OVF 5
`define IRQ_BIT_TMR1_OVF 7
`define IRQ_MASK_FLAGS   8'haf

// Hardware call length in clock cycles
`define IRQ_CALL_CYCLES  4

// Vector addresses in polling order
`define IRQ_VEC_EXT0     16'h0003
`define IRQ_VEC_TMR0     16'h000b
`define IRQ_VEC_EXT1     16'h0013
`define IRQ_VEC_TMR1     16'h001b
`define IRQ_VEC_CARRAY   16'h0033
`define IRQ_VEC_SERIAL   16'h0023
`define IRQ_VEC_TMR2     16'h002b
`define IRQ_VEC_KEYBD    16'h003b
`define IRQ_VEC_TWOWIRE  16'h0043
`define IRQ_VEC_SPI      16'h004b
`define IRQ_VEC_COMPAR   16'h005b
`define IRQ_VEC_CONVERT  16'h0063

`endif

// *** verilog/irq_resp_pkg.sv ***
package irq_resp_pkg;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  // Raw source flags held by peripherals outside this block
  typedef struct packed {
    logic [1:0] serial_port;
    logic [1:0] timer_two;
    logic [5:0] counter_array;
    logic [7:0] keyboard;
    logic       two_wire_port;
    logic [2:0] serial_periph;
    logic [1:0] comparator;
    logic       converter;
  } periph_flags_s;

  // Hardware call sequencing
  typedef enum logic [1:0] {
    CALL_IDLE = 2'b01,
    CALL_BUSY = 2'b10
  } call_state_e;

  typedef logic [11:0] src_vec_t;

endpackage

// *** verif/irq_resp_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_resp_asserts (
  input wire logic                   i_mclk,
  input wire logic                   i_rst,
  input wire irq_resp_pkg::reg_req_s i_reg,
  input wire logic [7:0]             o_reg_rdata,
  input wire logic                   i_instr_last,
  input wire logic                   i_instr_return_from_interrupt,
  input wire logic                   o_call_req,
  input wire logic [15:0]            o_call_vector,
  input wire logic [3:0]             o_active_levels
);
  logic gate_q;
  logic gate_d;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // Shadow of the global gate bit
  always_comb begin
    gate_d = gate_q;
    if (i_reg.wr && i_reg.addr == 8'ha8) gate_d = i_reg.wdata[7];
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) gate_q <= 1'b0;
    else gate_q <= gate_d;
  end

  chk_rdata_idle: assert property (!$past(i_reg.rd) |-> o_reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_en1_unused: assert property ($past(i_reg.rd && i_reg.addr == 8'hb1) |->
    (o_reg_rdata & 8'hc8) == 8'h00) else $error("unused enable bits set");
  chk_call_poll: assert property (o_call_req |-> $past(i_instr_last))
    else $error("call outside poll");
  chk_return_from_interrupt_block: assert property ($past(i_instr_last && i_instr_return_from_interrupt) |-> !o_call_req)
    else $error("call after return");
  chk_write_block: assert property (i_reg.wr && (i_reg.addr == 8'ha8 ||
    i_reg.addr == 8'hb1) |=> !o_call_req) else $error("call after enable write");
  chk_gate_mask: assert property (o_call_req |-> $past(gate_q))
    else $error("call with gate closed");
  chk_call_guard: assert property (o_call_req |=> !o_call_req [*3])
    else $error("call inside call");
  chk_level_rise: assert property (o_call_req |-> o_active_levels > $past(o_active_levels))
    else $error("level not raised");
  chk_level_return: assert property (i_instr_last && i_instr_return_from_interrupt && o_active_levels != 4'h0
    |=> o_active_levels < $past(o_active_levels)) else $error("level not dropped");
  chk_vector_hold: assert property (!o_call_req |-> $stable(o_call_vector))
    else $error("vector moved");
endmodule // irq_resp_asserts
`default_nettype wire

// *** verif/irq_seq_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_seq_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_call,
  input  wire logic       i_return_from_interrupt_req,
  input  wire logic [2:0] i_len,
  output logic            o_last,
  output logic            o_return_from_interrupt
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [2:0] hold_q;
  logic [2:0] hold_d;

  // Instruction cycle count, held at zero while the call runs
  always_comb begin
    hold_d = (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
    cnt_d  = (o_last || hold_q != 3'h0) ? 3'h0 : cnt_q + 3'h1;
    if (i_call) begin
      hold_d = 3'h3;
      cnt_d  = 3'h0;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= 3'h0;
      hold_q <= 3'h0;
    end else begin
      cnt_q  <= cnt_d;
      hold_q <= hold_d;
    end
  end
  // Final cycle and return marker
  assign o_last = !i_call && hold_q == 3'h0 && cnt_q == i_len - 3'h1;
  assign o_return_from_interrupt = o_last && i_return_from_interrupt_req;
endmodule // irq_seq_model
`default_nettype wire

// *** verif/test_interrupt_response_and_enable.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_response_and_enable;
  import irq_resp_pkg::*;
  logic          i_mclk = 1'b0;
  logic          i_rst = 1'b1;
  reg_req_s      req = '0;
  logic          ext0 = 1'b0;
  logic          ext1 = 1'b0;
  logic          t0_roll = 1'b0;
  logic          t1_roll = 1'b0;
  periph_flags_s pflags = '0;
  logic          return_from_interrupt_req = 1'b0;
  logic          last;
  logic          return_from_interrupt;
  logic          call;
  logic [7:0]    rdata;
  logic [15:0]   vec;
  logic [3:0]    act;
  int            mismatches = 0;
  int            cmp_count = 0;

  // 40 MHz clock
  always #12.5 i_mclk = ~i_mclk;

  interrupt_response_and_enable i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1),
    .i_reg(req), .o_reg_rdata(rdata), .i_ext_req_zero(ext0), .i_ext_req_one(ext1),
    .i_timer_zero_rollover(t0_roll), .i_timer_one_rollover(t1_roll), .i_periph_flags(pflags),
    .i_instr_last(last), .i_instr_return_from_interrupt(return_from_interrupt), .o_call_req(call), .o_call_vector(vec),
    .o_active_levels(act));
  irq_seq_model i_seq (.i_mclk(i_mclk), .i_rst(i_rst), .i_call(call), .i_return_from_interrupt_req(return_from_interrupt_req),
    .i_len(3'd5), .o_last(last), .o_return_from_interrupt(return_from_interrupt));

  // Verdict
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    req <= '0;
    #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask
  // Bounded waits on the call strobe
  task automatic wait_call(input logic [15:0] e);
    #1;
    for (int i = 0; i < 14 && call !== 1'b1; i++) @(posedge i_mclk) #1;
    chk("call", 16'h0001, {15'h0, call});
    if (call !== 1'b1) conclude();
    chk("vector", e, vec);
  endtask
  task automatic nc(input int n);
    repeat (n) @(posedge i_mclk) #1 chk("no call", 16'h0000, {15'h0, call});
  endtask
  task automatic ret;
    @(posedge i_mclk);
    return_from_interrupt_req <= 1'b1;
    #1;
    for (int i = 0; i < 10 && last !== 1'b1; i++) @(posedge i_mclk) #1;
    if (last !== 1'b1) begin
      mismatches++;
      conclude();
    end
    @(posedge i_mclk);
    return_from_interrupt_req <= 1'b0;
  endtask
  task automatic pulse;
    @(posedge i_mclk);
    t0_roll <= 1'b1;
    @(posedge i_mclk);
    t0_roll <= 1'b0;
  endtask
  // External one in edge mode, then timer one overflow
  task automatic ext_one_timer_one;
    wr(8'hc8, 8'h05);
    wr(8'ha8, 8'h8c);
    @(posedge i_mclk) ext1 <= 1'b1;
    @(posedge i_mclk) ext1 <= 1'b0;
    wait_call(16'h0013);
    rd(8'hc8, 8'h05);
    ret();
    @(posedge i_mclk) t1_roll <= 1'b1;
    @(posedge i_mclk) t1_roll <= 1'b0;
    wait_call(16'h001b);
    rd(8'hc8, 8'h05);
    ret();
  endtask

  // Main sequence
  initial begin
    cyc(10);
    i_rst <= 1'b0;
    rd(8'ha8, 8'h00);
    chk("vector", 16'h0000, vec);
    chk("levels", 16'h0000, {12'h000, act});
    rd(8'hb1, 8'h00);
    wr(8'hb1, 8'hff);
    rd(8'hb1, 8'h37);
    rd(8'h55, 8'h00);
    wr(8'hb1, 8'h00);
    wr(8'ha8, 8'h02);
    pulse();
    nc(12);
    rd(8'hc8, 8'h20);
    wr(8'hc8, 8'h00);
    wr(8'ha8, 8'h82);
    nc(12);
    pulse();
    wait_call(16'h000b);
    rd(8'hc8, 8'h00);
    ret();
    wr(8'hc8, 8'h01);
    wr(8'ha8, 8'h81);
    @(posedge i_mclk) ext0 <= 1'b1;
    @(posedge i_mclk) ext0 <= 1'b0;
    wait_call(16'h0003);
    rd(8'hc8, 8'h01);
    ret();
    wr(8'hc8, 8'h00);
    @(posedge i_mclk) ext0 <= 1'b1;
    wait_call(16'h0003);
    rd(8'hc8, 8'h02);
    @(posedge i_mclk) ext0 <= 1'b0;
    cyc(4);
    ret();
    nc(12);
    wr(8'ha8, 8'h83);
    wr(8'hc8, 8'h01);
    wr(8'hc8, 8'h23);
    wait_call(16'h0003);
    rd(8'hc9, 8'h01);
    rd(8'hc8, 8'h21);
    nc(10);
    ret();
    wait_call(16'h000b);
    ret();
    wr(8'ha8, 8'hd0);
    pflags.counter_array <= 6'h03;
    pflags.serial_port <= 2'h1;
    wait_call(16'h0033);
    @(posedge i_mclk) pflags.counter_array <= 6'h02;
    ret();
    wait_call(16'h0033);
    @(posedge i_mclk) pflags.counter_array <= 6'h00;
    ret();
    wait_call(16'h0023);
    @(posedge i_mclk) pflags.serial_port <= 2'h0;
    ret();
    ext_one_timer_one();
    nc(10);
    rd(8'hc9, 8'h00);
    chk("levels", 16'h0000, {12'h000, act});
    conclude();
  end
endmodule // test_interrupt_response_and_enable

bind interrupt_response_and_enable irq_resp_asserts u_chk (.i_mclk, .i_rst, .i_reg,
  .o_reg_rdata, .i_instr_last, .i_instr_return_from_interrupt, .o_call_req, .o_call_vector, .o_active_levels);
`default_nettype wire
